// ==== logic/timer16_control_status.sv ====
`timescale 1ns/100ps
module timer16_control_status #(
   parameter bit HAS_EXT_CLK = 1'b1
) (
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire timer16_pkg::bus_req_type bus_req_i,
   output logic [31:0] readdata_o,
   output logic waitrequest_o,
   input wire logic capture_one_pin_i,
   input wire logic capture_two_pin_i,
   input wire logic ext_count_pin_i,
   output timer16_pkg::compare_pins_type compare_pins_o,
   output logic irq_o
);
   timer16_pkg::bus_state_type bus_state_reg;
   logic [7:0] cr1_reg;
   logic [7:0] cr2_reg;
   logic timer_freeze_reg;
   logic [4:0] flags_reg;
   logic [4:0] flags_next;
   logic [4:0] armed_reg;
   logic [4:0] flag_set;
   logic [4:0] flag_clr;
   logic [15:0] counter_reg;
   logic [15:0] cap_one_reg;
   logic [15:0] cap_two_reg;
   logic [15:0] cmp_one_reg;
   logic [15:0] cmp_two_reg;
   logic [1:0] cmp_inhibit_reg;
   logic [2:0] presc_reg;
   logic cap1_prev_reg;
   logic cap2_prev_reg;
   logic ext_prev_reg;
   logic [7:0] readdata_reg;
   logic [7:0] read_mux;
   logic waitrequest_reg;
   logic irq_reg;
   timer16_pkg::compare_pins_type pins_reg;
   logic [5:0] idx;
   logic acc;
   logic rd_acc;
   logic wr_acc;
   logic tick;
   logic ext_edge;
   logic cap1_edge;
   logic cap2_edge;
   logic match_one;
   logic match_two;
   logic wrap;
   logic pwm_mode;
   logic pulse_mode;
   logic count_write;
   logic [1:0] count_clock_select;

   assign idx = bus_req_i.address[7:2];
   assign acc = (bus_state_reg == timer16_pkg::BUS_ANSWER);
   assign rd_acc = acc && bus_req_i.read;
   assign wr_acc = acc && bus_req_i.write && bus_req_i.byteenable[0];
   assign pwm_mode = cr2_reg[timer16_pkg::CR2_PWM];
   assign pulse_mode = cr2_reg[timer16_pkg::CR2_PULSE] && !pwm_mode;
   assign count_clock_select = cr2_reg[timer16_pkg::CR2_CLK_HI:timer16_pkg::CR2_CLK_LO];
   assign count_write = wr_acc && (idx == timer16_pkg::CNT_LO_IDX || idx == timer16_pkg::ALT_LO_IDX);

   // Pins are taken as synchronous, so one stage of history is enough for edge detection.
   assign ext_edge = cr2_reg[timer16_pkg::CR2_EXT_EDGE] ? (!ext_prev_reg && ext_count_pin_i)
                                                         : (ext_prev_reg && !ext_count_pin_i);
   assign cap1_edge = cr1_reg[timer16_pkg::CR1_CAP1_EDGE] ? (!cap1_prev_reg && capture_one_pin_i)
                                                           : (cap1_prev_reg && !capture_one_pin_i);
   assign cap2_edge = cr2_reg[timer16_pkg::CR2_CAP2_EDGE] ? (!cap2_prev_reg && capture_two_pin_i)
                                                           : (cap2_prev_reg && !capture_two_pin_i);

   always_comb begin
      case (count_clock_select)
         2'b00: tick = (presc_reg[1:0] == 2'b11);
         2'b01: tick = presc_reg[0];
         2'b10: tick = (presc_reg == 3'b111);
         default: tick = HAS_EXT_CLK && ext_edge;
      endcase
      if (timer_freeze_reg) begin
         tick = 1'b0;
      end
   end

   // Matches are judged once per count step so a long-held count cannot retrigger.
   assign match_one = tick && !cmp_inhibit_reg[0] && (counter_reg == cmp_one_reg);
   assign match_two = tick && !cmp_inhibit_reg[1] && (counter_reg == cmp_two_reg);
   assign wrap = tick && (counter_reg == timer16_pkg::COUNT_TOP) && !(pwm_mode && match_two);

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         presc_reg <= timer16_pkg::PRESC_RESET;
      end else if (!timer_freeze_reg) begin
         presc_reg <= presc_reg + 3'h1;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         cap1_prev_reg <= 1'b0;
         cap2_prev_reg <= 1'b0;
         ext_prev_reg <= 1'b0;
      end else begin
         cap1_prev_reg <= capture_one_pin_i;
         cap2_prev_reg <= capture_two_pin_i;
         ext_prev_reg <= ext_count_pin_i;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         counter_reg <= timer16_pkg::COUNT_RESET;
      end else if (count_write) begin
         counter_reg <= timer16_pkg::COUNT_RESET;
      end else if (pulse_mode && cap1_edge) begin
         counter_reg <= timer16_pkg::COUNT_RESET;
      end else if (pwm_mode && match_two) begin
         counter_reg <= timer16_pkg::PWM_RELOAD;
      end else if (tick) begin
         counter_reg <= counter_reg + 16'h0001;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         cap_one_reg <= 16'h0000;
         cap_two_reg <= 16'h0000;
      end else begin
         if (pulse_mode && cap1_edge) begin
            cap_one_reg <= timer16_pkg::PULSE_CAPTURE;
         end else if (!pwm_mode && cap1_edge) begin
            cap_one_reg <= counter_reg;
         end
         if (cap2_edge) begin
            cap_two_reg <= counter_reg;
         end
      end
   end

   // A high byte write blocks matching until the low byte completes the new value.
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         cmp_one_reg <= timer16_pkg::CMP_RESET;
         cmp_two_reg <= timer16_pkg::CMP_RESET;
         cmp_inhibit_reg <= 2'b00;
      end else if (wr_acc) begin
         case (idx)
            timer16_pkg::CMP1_HI_IDX: begin
               cmp_one_reg[15:8] <= bus_req_i.writedata[7:0];
               cmp_inhibit_reg[0] <= 1'b1;
            end
            timer16_pkg::CMP1_LO_IDX: begin
               cmp_one_reg[7:0] <= bus_req_i.writedata[7:0];
               cmp_inhibit_reg[0] <= 1'b0;
            end
            timer16_pkg::CMP2_HI_IDX: begin
               cmp_two_reg[15:8] <= bus_req_i.writedata[7:0];
               cmp_inhibit_reg[1] <= 1'b1;
            end
            timer16_pkg::CMP2_LO_IDX: begin
               cmp_two_reg[7:0] <= bus_req_i.writedata[7:0];
               cmp_inhibit_reg[1] <= 1'b0;
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         cr1_reg <= timer16_pkg::CTRL_RESET;
         cr2_reg <= timer16_pkg::CTRL_RESET;
         timer_freeze_reg <= 1'b0;
      end else if (wr_acc) begin
         if (idx == timer16_pkg::CR1_IDX) begin
            cr1_reg <= bus_req_i.writedata[7:0];
         end
         if (idx == timer16_pkg::CR2_IDX) begin
            cr2_reg <= bus_req_i.writedata[7:0];
         end
         if (idx == timer16_pkg::CSR_IDX) begin
            timer_freeze_reg <= bus_req_i.writedata[timer16_pkg::CSR_FREEZE];
         end
      end
   end

   always_comb begin
      flag_set = 5'b00000;
      flag_set[timer16_pkg::FLAG_CAP_ONE] = (cap1_edge && !pwm_mode) || (pwm_mode && match_two);
      flag_set[timer16_pkg::FLAG_CMP_ONE] = match_one && !pwm_mode && !pulse_mode;
      flag_set[timer16_pkg::FLAG_WRAP] = wrap;
      flag_set[timer16_pkg::FLAG_CAP_TWO] = cap2_edge;
      flag_set[timer16_pkg::FLAG_CMP_TWO] = match_two && !pwm_mode;
      flag_clr = 5'b00000;
      if (acc) begin
         flag_clr[timer16_pkg::FLAG_CAP_ONE] = (idx == timer16_pkg::CAP1_LO_IDX);
         flag_clr[timer16_pkg::FLAG_CMP_ONE] = (idx == timer16_pkg::CMP1_LO_IDX);
         flag_clr[timer16_pkg::FLAG_WRAP] = (idx == timer16_pkg::CNT_LO_IDX);
         flag_clr[timer16_pkg::FLAG_CAP_TWO] = (idx == timer16_pkg::CAP2_LO_IDX);
         flag_clr[timer16_pkg::FLAG_CMP_TWO] = (idx == timer16_pkg::CMP2_LO_IDX);
      end
      flag_clr = flag_clr & armed_reg;
      flags_next = (flags_reg & ~flag_clr) | flag_set;
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         flags_reg <= 5'b00000;
      end else begin
         flags_reg <= flags_next;
      end
   end

   // Arming uses the very byte that software read, so a flag raised after that read is never lost.
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         armed_reg <= 5'b00000;
      end else if (rd_acc && idx == timer16_pkg::CSR_IDX) begin
         armed_reg <= readdata_reg[7:3];
      end else begin
         armed_reg <= armed_reg & ~flag_clr;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         irq_reg <= 1'b0;
      end else begin
         irq_reg <= (cr1_reg[timer16_pkg::CR1_CAP_IE] && (flags_reg[timer16_pkg::FLAG_CAP_ONE]
                     || flags_reg[timer16_pkg::FLAG_CAP_TWO]))
                    || (cr1_reg[timer16_pkg::CR1_CMP_IE] && (flags_reg[timer16_pkg::FLAG_CMP_ONE]
                     || flags_reg[timer16_pkg::FLAG_CMP_TWO]))
                    || (cr1_reg[timer16_pkg::CR1_WRAP_IE] && flags_reg[timer16_pkg::FLAG_WRAP]);
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         pins_reg <= '0;
      end else begin
         pins_reg.enable_one <= cr2_reg[timer16_pkg::CR2_PIN1_EN] && !timer_freeze_reg;
         pins_reg.enable_two <= cr2_reg[timer16_pkg::CR2_PIN2_EN] && !timer_freeze_reg;
         if (cr1_reg[timer16_pkg::CR1_FORCE_ONE] && cr2_reg[timer16_pkg::CR2_PIN1_EN]) begin
            pins_reg.level_one <= cr1_reg[timer16_pkg::CR1_LEVEL_ONE];
         end else if ((pwm_mode && match_two) || (pulse_mode && cap1_edge)) begin
            pins_reg.level_one <= cr1_reg[timer16_pkg::CR1_LEVEL_TWO];
         end else if (match_one) begin
            pins_reg.level_one <= cr1_reg[timer16_pkg::CR1_LEVEL_ONE];
         end
         if (cr1_reg[timer16_pkg::CR1_FORCE_TWO] && cr2_reg[timer16_pkg::CR2_PIN2_EN]) begin
            pins_reg.level_two <= cr1_reg[timer16_pkg::CR1_LEVEL_TWO];
         end else if (match_two && !pwm_mode && !pulse_mode) begin
            pins_reg.level_two <= cr1_reg[timer16_pkg::CR1_LEVEL_TWO];
         end
      end
   end

   always_comb begin
      case (idx)
         timer16_pkg::CR1_IDX: read_mux = cr1_reg;
         timer16_pkg::CR2_IDX: read_mux = cr2_reg;
         timer16_pkg::CSR_IDX: read_mux = {flags_reg, timer_freeze_reg, 2'b00};
         timer16_pkg::CAP1_HI_IDX: read_mux = cap_one_reg[15:8];
         timer16_pkg::CAP1_LO_IDX: read_mux = cap_one_reg[7:0];
         timer16_pkg::CMP1_HI_IDX: read_mux = cmp_one_reg[15:8];
         timer16_pkg::CMP1_LO_IDX: read_mux = cmp_one_reg[7:0];
         timer16_pkg::CNT_HI_IDX: read_mux = counter_reg[15:8];
         timer16_pkg::CNT_LO_IDX: read_mux = counter_reg[7:0];
         timer16_pkg::ALT_HI_IDX: read_mux = counter_reg[15:8];
         timer16_pkg::ALT_LO_IDX: read_mux = counter_reg[7:0];
         timer16_pkg::CAP2_HI_IDX: read_mux = cap_two_reg[15:8];
         timer16_pkg::CAP2_LO_IDX: read_mux = cap_two_reg[7:0];
         timer16_pkg::CMP2_HI_IDX: read_mux = cmp_two_reg[15:8];
         timer16_pkg::CMP2_LO_IDX: read_mux = cmp_two_reg[7:0];
         default: read_mux = 8'h00;
      endcase
   end

   // Every access gets exactly one wait cycle; side effects land on the completing edge.
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         bus_state_reg <= timer16_pkg::BUS_IDLE;
         waitrequest_reg <= 1'b1;
         readdata_reg <= 8'h00;
      end else begin
         case (bus_state_reg)
            timer16_pkg::BUS_IDLE: begin
               if (bus_req_i.read || bus_req_i.write) begin
                  bus_state_reg <= timer16_pkg::BUS_ANSWER;
                  waitrequest_reg <= 1'b0;
                  readdata_reg <= bus_req_i.read ? read_mux : 8'h00;
               end
            end
            timer16_pkg::BUS_ANSWER: begin
               bus_state_reg <= timer16_pkg::BUS_IDLE;
               waitrequest_reg <= 1'b1;
            end
            default: begin
               bus_state_reg <= timer16_pkg::BUS_IDLE;
               waitrequest_reg <= 1'b1;
            end
         endcase
      end
   end

   assign readdata_o = {24'h00_0000, readdata_reg};
   assign waitrequest_o = waitrequest_reg;
   assign irq_o = irq_reg;
   assign compare_pins_o = pins_reg;

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (sys_rst_i);

   a_capture_irq_gate: assert property (cr1_reg[7] && (flags_reg[4] || flags_reg[1]) |=> irq_o)
      else $error("capture flag with enable did not raise irq");
   a_compare_irq_gate: assert property (cr1_reg[6] && (flags_reg[3] || flags_reg[0]) |=> irq_o)
      else $error("compare flag with enable did not raise irq");
   a_wrap_irq_gate: assert property (cr1_reg[5] && flags_reg[2] |=> irq_o)
      else $error("wrap flag with enable did not raise irq");
   a_irq_has_cause: assert property (irq_o |-> $past(|(flags_reg & {cr1_reg[7], cr1_reg[6], cr1_reg[5],
                                     cr1_reg[7], cr1_reg[6]})))
      else $error("irq raised without an enabled flag");
   a_freeze_pins_off: assert property (timer_freeze_reg |=> !compare_pins_o.enable_one
                                       && !compare_pins_o.enable_two)
      else $error("compare pins driven while frozen");
   a_freeze_count_hold: assert property (timer_freeze_reg && !count_write && !(pulse_mode && cap1_edge)
                                         |=> $stable(counter_reg))
      else $error("counter moved while frozen");
   a_wrap_sets_flag: assert property (tick && counter_reg == 16'hFFFF && !pwm_mode |=> flags_reg[2])
      else $error("wrap did not set wrap flag");
   a_pwm_reload_value: assert property (pwm_mode && match_two && !count_write |=> counter_reg == 16'hFFFC)
      else $error("pwm period end did not reload counter");
   a_count_write_reset: assert property (count_write |=> counter_reg == 16'hFFFC)
      else $error("counter low write did not reset counter");
   a_divide_eight_tick: assert property (count_clock_select == 2'b10 && tick |-> presc_reg == 3'b111)
      else $error("divide by eight tick off phase");
   a_no_ext_stop: assert property (!HAS_EXT_CLK && count_clock_select == 2'b11 |-> !tick)
      else $error("counter advanced with absent external clock");
   a_unarmed_flag_kept: assert property (flags_reg[2] && !armed_reg[2] |=> flags_reg[2])
      else $error("unarmed wrap flag was cleared");
   a_bus_one_wait: assert property ((bus_req_i.read || bus_req_i.write) && waitrequest_o
                                    |=> !waitrequest_o ##1 waitrequest_o)
      else $error("bus answer not one wait cycle");

   c_pwm_reload: cover property (pwm_mode && match_two);
   c_pulse_trigger: cover property (pulse_mode && cap1_edge);
   c_irq_rise: cover property (!irq_o ##1 irq_o);
   c_flag_cleared: cover property (flags_reg[2] ##1 !flags_reg[2]);
endmodule // timer16_control_status

// ==== pkg/timer16_pkg.sv ====
// Behaviour
// - Capture interrupt enable passes either capture flag onto the timer interrupt request.
// - Compare interrupt enable passes either compare flag onto the timer interrupt request.
// - Overflow interrupt enable passes the wrap flag onto the timer interrupt request.
// - All enabled timer events share one interrupt request; the CPU applies its mask.
// - Timer interrupt wakes from wait, not halt; compare events absent in PWM mode.
// - A set force bit copies its level onto an enabled compare pin without match.
// - Level two goes to compare pin two on match two; pin one in pulse modes.
// - Level one goes to compare pin one on each match with compare value one.
// - Capture edge selects: zero captures falling edges, one captures rising edges.
// - Compare pin enables only route outputs; matching and flags keep working.
// - Single pulse mode: selected capture one edge starts one pulse on compare pin one.
// - PWM mode: compare one sets pulse length, compare two sets the period.
// - Clock select: 00 divide 4, 01 divide 2, 10 divide 8, 11 external.
// - Without an external clock pin, external selection stops the counter.
// - External edge select: zero counts falling edges, one counts rising edges.
// - Capture one flag: set on capture one or PWM period end; cleared two-step.
// - Compare one flag: set on match one outside PWM and single pulse modes; cleared by status read then low byte access.
// - Wrap flag: set on FFFF to 0000; counter low access clears, alternate never.
// - Capture two flag: set on capture two; cleared by status read then low byte.
// - Compare two flag: set on match two outside PWM mode; cleared by status read then low byte.
// - Freeze bit halts prescaler and counter, disables pins; registers stay accessible.
// - In PWM mode each compare two match reloads the counter with FFFC.
// - A write to the counter low byte resets the counter to its reset value.
package timer16_pkg;
   localparam logic [5:0] CR2_IDX = 6'h31;
   localparam logic [5:0] CR1_IDX = 6'h32;
   localparam logic [5:0] CSR_IDX = 6'h33;
   localparam logic [5:0] CAP1_HI_IDX = 6'h34;
   localparam logic [5:0] CAP1_LO_IDX = 6'h35;
   localparam logic [5:0] CMP1_HI_IDX = 6'h36;
   localparam logic [5:0] CMP1_LO_IDX = 6'h37;
   localparam logic [5:0] CNT_HI_IDX = 6'h38;
   localparam logic [5:0] CNT_LO_IDX = 6'h39;
   localparam logic [5:0] ALT_HI_IDX = 6'h3A;
   localparam logic [5:0] ALT_LO_IDX = 6'h3B;
   localparam logic [5:0] CAP2_HI_IDX = 6'h3C;
   localparam logic [5:0] CAP2_LO_IDX = 6'h3D;
   localparam logic [5:0] CMP2_HI_IDX = 6'h3E;
   localparam logic [5:0] CMP2_LO_IDX = 6'h3F;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [15:0] CMP_RESET = 16'h8000;
   localparam logic [15:0] COUNT_RESET = 16'hFFFC;
   localparam logic [15:0] PWM_RELOAD = 16'hFFFC;
   localparam logic [15:0] PULSE_CAPTURE = 16'hFFFD;
   localparam logic [15:0] COUNT_TOP = 16'hFFFF;
   localparam logic [2:0] PRESC_RESET = 3'h0;
   localparam int CR1_CAP_IE = 7;
   localparam int CR1_CMP_IE = 6;
   localparam int CR1_WRAP_IE = 5;
   localparam int CR1_FORCE_TWO = 4;
   localparam int CR1_FORCE_ONE = 3;
   localparam int CR1_LEVEL_TWO = 2;
   localparam int CR1_CAP1_EDGE = 1;
   localparam int CR1_LEVEL_ONE = 0;
   localparam int CR2_PIN1_EN = 7;
   localparam int CR2_PIN2_EN = 6;
   localparam int CR2_PULSE = 5;
   localparam int CR2_PWM = 4;
   localparam int CR2_CLK_HI = 3;
   localparam int CR2_CLK_LO = 2;
   localparam int CR2_CAP2_EDGE = 1;
   localparam int CR2_EXT_EDGE = 0;
   localparam int CSR_FREEZE = 2;
   localparam int FLAG_CAP_ONE = 4;
   localparam int FLAG_CMP_ONE = 3;
   localparam int FLAG_WRAP = 2;
   localparam int FLAG_CAP_TWO = 1;
   localparam int FLAG_CMP_TWO = 0;
   typedef struct packed {
      logic read;
      logic write;
      logic [7:0] address;
      logic [3:0] byteenable;
      logic [31:0] writedata;
   } bus_req_type;
   typedef struct packed {
      logic level_one;
      logic enable_one;
      logic level_two;
      logic enable_two;
   } compare_pins_type;
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ANSWER = 2'b10
   } bus_state_type;
endpackage

// ==== test/pin_partner.sv ====
`timescale 1ns/100ps
module pin_partner (
   input wire logic core_clk_i,
   output logic cap_one_o,
   output logic cap_two_o,
   output logic ext_o
);
   initial begin
      cap_one_o = 1'b0;
      cap_two_o = 1'b0;
      ext_o = 1'b0;
   end
   // Levels are held several cycles so the sampled-edge detector cannot miss them.
   task automatic set_cap(input int which, input logic val);
      @(posedge core_clk_i);
      if (which == 1) cap_one_o <= val;
      else cap_two_o <= val;
      repeat (4) @(posedge core_clk_i);
   endtask
   task automatic ext_pulses(input int n);
      repeat (n) begin
         @(posedge core_clk_i);
         ext_o <= 1'b1;
         repeat (3) @(posedge core_clk_i);
         ext_o <= 1'b0;
         repeat (3) @(posedge core_clk_i);
      end
   endtask
endmodule // pin_partner

// ==== test/tb_top.sv ====
`timescale 1ns/100ps
module tb_top;
   logic core_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   timer16_pkg::bus_req_type bus_req = '0;
   logic [31:0] readdata;
   logic waitrequest;
   logic cap_one;
   logic cap_two;
   logic ext_pin;
   timer16_pkg::compare_pins_type pins;
   logic irq;
   int n_mismatch = 0;
   int n_tests = 0;
   logic [7:0] d;
   int step[4] = '{12, 24, 6, 5};
   always #12.5 core_clk_i = ~core_clk_i;
   pin_partner pin_partner_inst (.core_clk_i(core_clk_i), .cap_one_o(cap_one), .cap_two_o(cap_two), .ext_o(ext_pin));
   timer16_control_status timer16_control_status_inst (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
      .bus_req_i(bus_req), .readdata_o(readdata), .waitrequest_o(waitrequest), .capture_one_pin_i(cap_one),
      .capture_two_pin_i(cap_two), .ext_count_pin_i(ext_pin), .compare_pins_o(pins), .irq_o(irq));
   task automatic stop_test();
      $display("Comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // A tolerance absorbs the free prescaler phase, which software cannot see.
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen, input logic [7:0] tol);
      n_tests++;
      if ($isunknown(seen) || 8'(seen - exp) > tol) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic acc(input logic wr, input logic [5:0] idx, input logic [7:0] wd, output logic [7:0] rd);
      int n;
      n = 0;
      @(posedge core_clk_i);
      bus_req <= '{read: !wr, write: wr, address: {idx, 2'b00}, byteenable: 4'h1, writedata: {24'h00_0000, wd}};
      do begin
         @(posedge core_clk_i);
         n++;
      end while (waitrequest !== 1'b0 && n < 50);
      if (n == 50) n_mismatch++;
      rd = readdata[7:0];
      bus_req <= '0;
   endtask
   task automatic wr(input logic [5:0] idx, input logic [7:0] wd);
      acc(1'b1, idx, wd, d);
   endtask
   task automatic rd_chk(input string name, input logic [5:0] idx, input logic [7:0] exp, input logic [7:0] tol);
      acc(1'b0, idx, 8'h00, d);
      chk(name, exp, d, tol);
   endtask
   task automatic pause();
      repeat (3) @(posedge core_clk_i);
   endtask
   initial begin
      repeat (16) @(posedge core_clk_i);
      sys_rst_i <= 1'b0;
      rd_chk("cr1", timer16_pkg::CR1_IDX, 8'h00, 0);
      rd_chk("cr2", timer16_pkg::CR2_IDX, 8'h00, 0);
      rd_chk("cmp1_hi", timer16_pkg::CMP1_HI_IDX, 8'h80, 0);
      rd_chk("unmapped", 6'h00, 8'h00, 0);
      wr(timer16_pkg::CR1_IDX, 8'h20);
      for (int i = 0; i < 4; i++) begin
         wr(timer16_pkg::CSR_IDX, 8'h04);
         wr(timer16_pkg::CR2_IDX, {4'h0, 2'(i), 2'b01});
         wr(timer16_pkg::CNT_LO_IDX, 8'h00);
         wr(timer16_pkg::CSR_IDX, 8'h00);
         if (i == 3) pin_partner_inst.ext_pulses(5);
         else repeat (48) @(posedge core_clk_i);
         wr(timer16_pkg::CSR_IDX, 8'h04);
         rd_chk("wrap", timer16_pkg::CSR_IDX, 8'h24, 0);
         rd_chk("alt_lo", timer16_pkg::ALT_LO_IDX, 8'hFC + 8'(step[i]), 2);
         rd_chk("wrap_kept", timer16_pkg::CSR_IDX, 8'h24, 0);
         chk("irq_wrap", 8'h01, {7'h0, irq}, 0);
         rd_chk("cnt_lo", timer16_pkg::CNT_LO_IDX, 8'hFC + 8'(step[i]), 2);
      end
      rd_chk("wrap_clear", timer16_pkg::CSR_IDX, 8'h04, 0);
      pause();
      chk("irq_idle", 8'h00, {7'h0, irq}, 0);
      wr(timer16_pkg::CR1_IDX, 8'h80);
      wr(timer16_pkg::CR2_IDX, 8'h0E);
      pin_partner_inst.set_cap(2, 1'b1);
      rd_chk("cap2_flag", timer16_pkg::CSR_IDX, 8'h14, 0);
      chk("irq_cap", 8'h01, {7'h0, irq}, 0);
      rd_chk("cap2_lo", timer16_pkg::CAP2_LO_IDX, 8'h01, 0);
      pin_partner_inst.set_cap(2, 1'b0);
      pin_partner_inst.set_cap(1, 1'b1);
      rd_chk("cap_none", timer16_pkg::CSR_IDX, 8'h04, 0);
      pin_partner_inst.set_cap(1, 1'b0);
      rd_chk("cap1_flag", timer16_pkg::CSR_IDX, 8'h84, 0);
      wr(timer16_pkg::CR1_IDX, 8'h00);
      pause();
      chk("irq_masked", 8'h00, {7'h0, irq}, 0);
      rd_chk("cap1_lo", timer16_pkg::CAP1_LO_IDX, 8'h01, 0);
      rd_chk("cap1_clear", timer16_pkg::CSR_IDX, 8'h04, 0);
      wr(timer16_pkg::CMP1_HI_IDX, 8'h00);
      wr(timer16_pkg::CMP1_LO_IDX, 8'h05);
      wr(timer16_pkg::CMP2_HI_IDX, 8'h00);
      wr(timer16_pkg::CMP2_LO_IDX, 8'h08);
      wr(timer16_pkg::CR2_IDX, 8'hC4);
      wr(timer16_pkg::CR1_IDX, 8'h45);
      wr(timer16_pkg::CNT_LO_IDX, 8'h00);
      wr(timer16_pkg::CSR_IDX, 8'h00);
      repeat (40) @(posedge core_clk_i);
      chk("pins_match", 8'h0F, {4'h0, pins}, 0);
      wr(timer16_pkg::CSR_IDX, 8'h04);
      pause();
      chk("pins_frozen", 8'h0A, {4'h0, pins}, 0);
      rd_chk("cmp_flags", timer16_pkg::CSR_IDX, 8'h6C, 0);
      chk("irq_cmp", 8'h01, {7'h0, irq}, 0);
      rd_chk("cmp1_lo", timer16_pkg::CMP1_LO_IDX, 8'h05, 0);
      rd_chk("cmp1_clear", timer16_pkg::CSR_IDX, 8'h2C, 0);
      wr(timer16_pkg::CSR_IDX, 8'h00);
      wr(timer16_pkg::CR1_IDX, 8'h08);
      pause();
      chk("pins_force", 8'h07, {4'h0, pins}, 0);
      wr(timer16_pkg::CSR_IDX, 8'h04);
      rd_chk("pwm_arm", timer16_pkg::CSR_IDX, 8'h2C, 0);
      wr(timer16_pkg::CMP2_LO_IDX, 8'h08);
      wr(timer16_pkg::CR2_IDX, 8'h94);
      wr(timer16_pkg::CR1_IDX, 8'h84);
      wr(timer16_pkg::CNT_LO_IDX, 8'h00);
      wr(timer16_pkg::CSR_IDX, 8'h00);
      repeat (40) @(posedge core_clk_i);
      wr(timer16_pkg::CSR_IDX, 8'h04);
      rd_chk("pwm_flags", timer16_pkg::CSR_IDX, 8'hA4, 0);
      rd_chk("pwm_cnt_hi", timer16_pkg::CNT_HI_IDX, 8'hFF, 1);
      chk("irq_pwm", 8'h01, {7'h0, irq}, 0);
      stop_test();
   end
   initial begin
      repeat (20000) @(posedge core_clk_i);
      n_mismatch++;
      stop_test();
   end
endmodule // tb_top
